// ==== hw/pvn_pkg.sv ====
// package: offsets, field layout, reset values and carriers of the vector number bank
package pvn_pkg;

  localparam int REG_W = 16;
  localparam int VEC_W = 7;
  localparam int ADDR_W = 4;
  localparam int NUM_REGS = 7;
  localparam int IDX_W = 3;

  // halfword offsets on the register port
  localparam logic [3:0] OFF_T0_CD = 4'h0;
  localparam logic [3:0] OFF_T0_OVF = 4'h2;
  localparam logic [3:0] OFF_T1_AB = 4'h4;
  localparam logic [3:0] OFF_T1_WRAP = 4'h6;
  localparam logic [3:0] OFF_T2_AB = 4'h8;
  localparam logic [3:0] OFF_T2_WRAP = 4'ha;
  localparam logic [3:0] OFF_S1_RX = 4'hc;

  localparam logic [2:0] IDX_T0_CD = 3'h0;
  localparam logic [2:0] IDX_T0_OVF = 3'h1;
  localparam logic [2:0] IDX_T1_AB = 3'h2;
  localparam logic [2:0] IDX_T1_WRAP = 3'h3;
  localparam logic [2:0] IDX_T2_AB = 3'h4;
  localparam logic [2:0] IDX_T2_WRAP = 3'h5;
  localparam logic [2:0] IDX_S1_RX = 3'h6;

  localparam int HI_MSB = 14;
  localparam int HI_LSB = 8;
  localparam int LO_MSB = 6;
  localparam int LO_LSB = 0;

  localparam logic [15:0] RST_VAL = 16'h0000;
  localparam logic [15:0] MASK_PAIR = 16'h7f7f;
  localparam logic [15:0] MASK_HIGH = 16'h7f00;

  typedef enum logic [3:0] {
    SRC_U0_C = 4'h0,
    SRC_U0_D = 4'h1,
    SRC_U0_OVF = 4'h2,
    SRC_U1_A = 4'h3,
    SRC_U1_B = 4'h4,
    SRC_U1_OVF = 4'h5,
    SRC_U1_UDF = 4'h6,
    SRC_U2_A = 4'h7,
    SRC_U2_B = 4'h8,
    SRC_U2_OVF = 4'h9,
    SRC_U2_UDF = 4'ha,
    SRC_S1_ERR = 4'hb,
    SRC_S1_RXF = 4'hc
  } pvn_src_e;

  typedef struct packed {
    logic valid;
    pvn_src_e src;
  } pvn_ack_s;

  typedef struct packed {
    logic [6:0] unit0_chan_c_vec;
    logic [6:0] unit0_chan_d_vec;
    logic [6:0] unit0_ovf_vec;
    logic [6:0] unit1_chan_a_vec;
    logic [6:0] unit1_chan_b_vec;
    logic [6:0] unit1_ovf_vec;
    logic [6:0] unit1_udf_vec;
    logic [6:0] unit2_chan_a_vec;
    logic [6:0] unit2_chan_b_vec;
    logic [6:0] unit2_ovf_vec;
    logic [6:0] unit2_udf_vec;
    logic [6:0] serial1_rx_error_vec;
    logic [6:0] serial1_rx_full_vec;
  } pvn_vec_s;

endpackage : pvn_pkg

// ==== hw/pvn_regs.sv ====
// vector number setting bank for timer units 0..2 and fifo serial 1
`timescale 1ns/10ps

module pvn_regs (
  input wire logic clk_sys, // 25 MHz system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic [3:0] reg_addr, // register halfword offset
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, cycle after read
  input wire logic standby, // standby mode level
  input wire pvn_pkg::pvn_ack_s ack_in, // source accepted
  output pvn_pkg::pvn_vec_s vec_fields, // all vector fields
  output logic [6:0] vec_num, // vector of accepted source
  output logic vec_valid // vec_num valid pulse
);

  logic [15:0] bank_reg [pvn_pkg::NUM_REGS];
  logic [15:0] reg_rdata_next;
  logic [6:0] vec_num_next;
  logic [111:0] bank_flat;

  function automatic logic pvn_hit(input logic [3:0] a);
    logic h;
    h = 1'b0;
    if (a == pvn_pkg::OFF_T0_CD)
      h = 1'b1;
    else if (a == pvn_pkg::OFF_T0_OVF)
      h = 1'b1;
    else if (a == pvn_pkg::OFF_T1_AB)
      h = 1'b1;
    else if (a == pvn_pkg::OFF_T1_WRAP)
      h = 1'b1;
    else if (a == pvn_pkg::OFF_T2_AB)
      h = 1'b1;
    else if (a == pvn_pkg::OFF_T2_WRAP)
      h = 1'b1;
    else if (a == pvn_pkg::OFF_S1_RX)
      h = 1'b1;
    return h;
  endfunction : pvn_hit

  function automatic logic [2:0] pvn_idx(input logic [3:0] a);
    logic [2:0] i;
    i = pvn_pkg::IDX_T0_CD;
    if (a == pvn_pkg::OFF_T0_OVF)
      i = pvn_pkg::IDX_T0_OVF;
    else if (a == pvn_pkg::OFF_T1_AB)
      i = pvn_pkg::IDX_T1_AB;
    else if (a == pvn_pkg::OFF_T1_WRAP)
      i = pvn_pkg::IDX_T1_WRAP;
    else if (a == pvn_pkg::OFF_T2_AB)
      i = pvn_pkg::IDX_T2_AB;
    else if (a == pvn_pkg::OFF_T2_WRAP)
      i = pvn_pkg::IDX_T2_WRAP;
    else if (a == pvn_pkg::OFF_S1_RX)
      i = pvn_pkg::IDX_S1_RX;
    return i;
  endfunction : pvn_idx

  // reserved bits are never stored, so they cannot read back non-zero
  function automatic logic [15:0] pvn_mask(input logic [2:0] i);
    logic [15:0] m;
    m = pvn_pkg::MASK_PAIR;
    if (i == pvn_pkg::IDX_T0_OVF)
      m = pvn_pkg::MASK_HIGH;
    return m;
  endfunction : pvn_mask

  function automatic logic [6:0] pvn_hi(input logic [15:0] r);
    return r[pvn_pkg::HI_MSB:pvn_pkg::HI_LSB];
  endfunction : pvn_hi

  function automatic logic [6:0] pvn_lo(input logic [15:0] r);
    return r[pvn_pkg::LO_MSB:pvn_pkg::LO_LSB];
  endfunction : pvn_lo

  // standby is deliberately not a term here: contents survive it
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int k = 0; k < pvn_pkg::NUM_REGS; k++)
      begin
        bank_reg[k] <= pvn_pkg::RST_VAL;
      end
    end
    else if (reg_wr && pvn_hit(reg_addr))
    begin
      bank_reg[pvn_idx(reg_addr)] <= reg_wdata & pvn_mask(pvn_idx(reg_addr));
    end
  end

  always_comb
  begin
    reg_rdata_next = 16'h0000;
    if (reg_rd && pvn_hit(reg_addr))
      reg_rdata_next = bank_reg[pvn_idx(reg_addr)];
  end

  // read data stand for exactly one cycle, zero otherwise
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= reg_rdata_next;
  end

  always_comb
  begin
    vec_fields.unit0_chan_c_vec = pvn_hi(bank_reg[pvn_pkg::IDX_T0_CD]);
    vec_fields.unit0_chan_d_vec = pvn_lo(bank_reg[pvn_pkg::IDX_T0_CD]);
    vec_fields.unit0_ovf_vec = pvn_hi(bank_reg[pvn_pkg::IDX_T0_OVF]);
    vec_fields.unit1_chan_a_vec = pvn_hi(bank_reg[pvn_pkg::IDX_T1_AB]);
    vec_fields.unit1_chan_b_vec = pvn_lo(bank_reg[pvn_pkg::IDX_T1_AB]);
    vec_fields.unit1_ovf_vec = pvn_hi(bank_reg[pvn_pkg::IDX_T1_WRAP]);
    vec_fields.unit1_udf_vec = pvn_lo(bank_reg[pvn_pkg::IDX_T1_WRAP]);
    vec_fields.unit2_chan_a_vec = pvn_hi(bank_reg[pvn_pkg::IDX_T2_AB]);
    vec_fields.unit2_chan_b_vec = pvn_lo(bank_reg[pvn_pkg::IDX_T2_AB]);
    vec_fields.unit2_ovf_vec = pvn_hi(bank_reg[pvn_pkg::IDX_T2_WRAP]);
    vec_fields.unit2_udf_vec = pvn_lo(bank_reg[pvn_pkg::IDX_T2_WRAP]);
    vec_fields.serial1_rx_error_vec = pvn_hi(bank_reg[pvn_pkg::IDX_S1_RX]);
    vec_fields.serial1_rx_full_vec = pvn_lo(bank_reg[pvn_pkg::IDX_S1_RX]);
  end

  // an accept in the cycle of a write still sees the old field
  always_comb
  begin
    vec_num_next = 7'h00;
    case (ack_in.src)
      pvn_pkg::SRC_U0_C: vec_num_next = vec_fields.unit0_chan_c_vec;
      pvn_pkg::SRC_U0_D: vec_num_next = vec_fields.unit0_chan_d_vec;
      pvn_pkg::SRC_U0_OVF: vec_num_next = vec_fields.unit0_ovf_vec;
      pvn_pkg::SRC_U1_A: vec_num_next = vec_fields.unit1_chan_a_vec;
      pvn_pkg::SRC_U1_B: vec_num_next = vec_fields.unit1_chan_b_vec;
      pvn_pkg::SRC_U1_OVF: vec_num_next = vec_fields.unit1_ovf_vec;
      pvn_pkg::SRC_U1_UDF: vec_num_next = vec_fields.unit1_udf_vec;
      pvn_pkg::SRC_U2_A: vec_num_next = vec_fields.unit2_chan_a_vec;
      pvn_pkg::SRC_U2_B: vec_num_next = vec_fields.unit2_chan_b_vec;
      pvn_pkg::SRC_U2_OVF: vec_num_next = vec_fields.unit2_ovf_vec;
      pvn_pkg::SRC_U2_UDF: vec_num_next = vec_fields.unit2_udf_vec;
      pvn_pkg::SRC_S1_ERR: vec_num_next = vec_fields.serial1_rx_error_vec;
      pvn_pkg::SRC_S1_RXF: vec_num_next = vec_fields.serial1_rx_full_vec;
      default: vec_num_next = 7'h00;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      vec_num <= 7'h00;
      vec_valid <= 1'b0;
    end
    else
    begin
      vec_valid <= ack_in.valid;
      if (ack_in.valid)
        vec_num <= vec_num_next;
    end
  end

  always_comb
  begin
    bank_flat = '0;
    for (int k = 0; k < pvn_pkg::NUM_REGS; k++)
    begin
      bank_flat[k*16 +: 16] = bank_reg[k];
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  reset_clear_a: assert property (
    $fell(sys_rst) |-> (bank_flat == 112'h0))
    else $error("bank not zero after reset");

  rsvd_bits_a: assert property (
    $past(reg_rd) |-> (reg_rdata[15] == 1'b0 && reg_rdata[7] == 1'b0))
    else $error("reserved bit read as one");

  ovf0_low_a: assert property (
    reg_rd && reg_addr == pvn_pkg::OFF_T0_OVF |=> reg_rdata[7:0] == 8'h00)
    else $error("unit 0 overflow low byte not zero");

  write_back_a: assert property (
    reg_wr && pvn_hit(reg_addr) ##1 reg_rd && reg_addr == $past(reg_addr)
    |=> reg_rdata == ($past(reg_wdata, 2) &
    (($past(reg_addr, 2) == pvn_pkg::OFF_T0_OVF) ? pvn_pkg::MASK_HIGH : pvn_pkg::MASK_PAIR)))
    else $error("written value not read back");

  rd_idle_zero_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");

  standby_hold_a: assert property (
    standby && !reg_wr |=> $stable(bank_flat))
    else $error("bank changed in standby");

  unit0_cd_a: assert property (
    reg_wr && reg_addr == pvn_pkg::OFF_T0_CD |=>
    vec_fields.unit0_chan_c_vec == $past(reg_wdata[14:8]) &&
    vec_fields.unit0_chan_d_vec == $past(reg_wdata[6:0]))
    else $error("unit 0 c/d vector wrong");

  unit0_ovf_a: assert property (
    reg_wr && reg_addr == pvn_pkg::OFF_T0_OVF |=>
    vec_fields.unit0_ovf_vec == $past(reg_wdata[14:8]))
    else $error("unit 0 overflow vector wrong");

  unit1_ab_a: assert property (
    reg_wr && reg_addr == pvn_pkg::OFF_T1_AB |=>
    vec_fields.unit1_chan_a_vec == $past(reg_wdata[14:8]) &&
    vec_fields.unit1_chan_b_vec == $past(reg_wdata[6:0]))
    else $error("unit 1 a/b vector wrong");

  unit1_wrap_a: assert property (
    reg_wr && reg_addr == pvn_pkg::OFF_T1_WRAP |=>
    vec_fields.unit1_ovf_vec == $past(reg_wdata[14:8]) &&
    vec_fields.unit1_udf_vec == $past(reg_wdata[6:0]))
    else $error("unit 1 wrap vector wrong");

  unit2_ab_a: assert property (
    reg_wr && reg_addr == pvn_pkg::OFF_T2_AB |=>
    vec_fields.unit2_chan_a_vec == $past(reg_wdata[14:8]) &&
    vec_fields.unit2_chan_b_vec == $past(reg_wdata[6:0]))
    else $error("unit 2 a/b vector wrong");

  unit2_wrap_a: assert property (
    reg_wr && reg_addr == pvn_pkg::OFF_T2_WRAP |=>
    vec_fields.unit2_ovf_vec == $past(reg_wdata[14:8]) &&
    vec_fields.unit2_udf_vec == $past(reg_wdata[6:0]))
    else $error("unit 2 wrap vector wrong");

  serial1_rx_a: assert property (
    reg_wr && reg_addr == pvn_pkg::OFF_S1_RX |=>
    vec_fields.serial1_rx_error_vec == $past(reg_wdata[14:8]) &&
    vec_fields.serial1_rx_full_vec == $past(reg_wdata[6:0]))
    else $error("serial 1 vector wrong");

  ack_u0c_a: assert property (
    ack_in.valid && ack_in.src == pvn_pkg::SRC_U0_C |=>
    vec_valid && vec_num == $past(bank_reg[pvn_pkg::IDX_T0_CD][14:8]))
    else $error("channel c vector not presented");

  ack_s1rx_a: assert property (
    ack_in.valid && ack_in.src == pvn_pkg::SRC_S1_RXF |=>
    vec_valid && vec_num == $past(bank_reg[pvn_pkg::IDX_S1_RX][6:0]))
    else $error("receive full vector not presented");

  // one check per remaining source, each against its own register slice
  ack_u0d_a: assert property (
    ack_in.valid && ack_in.src == pvn_pkg::SRC_U0_D |=>
    vec_valid && vec_num == $past(bank_reg[pvn_pkg::IDX_T0_CD][6:0]))
    else $error("channel d vector not presented");

  ack_u0ovf_a: assert property (
    ack_in.valid && ack_in.src == pvn_pkg::SRC_U0_OVF |=>
    vec_valid && vec_num == $past(bank_reg[pvn_pkg::IDX_T0_OVF][14:8]))
    else $error("unit 0 overflow vector not presented");

  ack_u1a_a: assert property (
    ack_in.valid && ack_in.src == pvn_pkg::SRC_U1_A |=>
    vec_valid && vec_num == $past(bank_reg[pvn_pkg::IDX_T1_AB][14:8]))
    else $error("unit 1 channel a vector not presented");

  ack_u1b_a: assert property (
    ack_in.valid && ack_in.src == pvn_pkg::SRC_U1_B |=>
    vec_valid && vec_num == $past(bank_reg[pvn_pkg::IDX_T1_AB][6:0]))
    else $error("unit 1 channel b vector not presented");

  ack_u1ovf_a: assert property (
    ack_in.valid && ack_in.src == pvn_pkg::SRC_U1_OVF |=>
    vec_valid && vec_num == $past(bank_reg[pvn_pkg::IDX_T1_WRAP][14:8]))
    else $error("unit 1 overflow vector not presented");

  ack_u1udf_a: assert property (
    ack_in.valid && ack_in.src == pvn_pkg::SRC_U1_UDF |=>
    vec_valid && vec_num == $past(bank_reg[pvn_pkg::IDX_T1_WRAP][6:0]))
    else $error("unit 1 underflow vector not presented");

  ack_u2a_a: assert property (
    ack_in.valid && ack_in.src == pvn_pkg::SRC_U2_A |=>
    vec_valid && vec_num == $past(bank_reg[pvn_pkg::IDX_T2_AB][14:8]))
    else $error("unit 2 channel a vector not presented");

  ack_u2b_a: assert property (
    ack_in.valid && ack_in.src == pvn_pkg::SRC_U2_B |=>
    vec_valid && vec_num == $past(bank_reg[pvn_pkg::IDX_T2_AB][6:0]))
    else $error("unit 2 channel b vector not presented");

  ack_u2ovf_a: assert property (
    ack_in.valid && ack_in.src == pvn_pkg::SRC_U2_OVF |=>
    vec_valid && vec_num == $past(bank_reg[pvn_pkg::IDX_T2_WRAP][14:8]))
    else $error("unit 2 overflow vector not presented");

  ack_u2udf_a: assert property (
    ack_in.valid && ack_in.src == pvn_pkg::SRC_U2_UDF |=>
    vec_valid && vec_num == $past(bank_reg[pvn_pkg::IDX_T2_WRAP][6:0]))
    else $error("unit 2 underflow vector not presented");

  ack_s1err_a: assert property (
    ack_in.valid && ack_in.src == pvn_pkg::SRC_S1_ERR |=>
    vec_valid && vec_num == $past(bank_reg[pvn_pkg::IDX_S1_RX][14:8]))
    else $error("receive error vector not presented");

  ack_bad_src_a: assert property (
    ack_in.valid && ack_in.src > pvn_pkg::SRC_S1_RXF |=>
    vec_valid && vec_num == 7'h00)
    else $error("unknown source gave a vector");

  unmapped_rd_a: assert property (
    reg_rd && !pvn_hit(reg_addr) |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");

  unmapped_wr_a: assert property (
    reg_wr && !pvn_hit(reg_addr) |=> $stable(bank_flat))
    else $error("unmapped write changed the bank");

  rsvd_store_a: assert property (
    (bank_flat & {pvn_pkg::MASK_PAIR, pvn_pkg::MASK_PAIR, pvn_pkg::MASK_PAIR, pvn_pkg::MASK_PAIR,
    pvn_pkg::MASK_PAIR, pvn_pkg::MASK_HIGH, pvn_pkg::MASK_PAIR}) == bank_flat)
    else $error("reserved bit stored");

  fields_rst_a: assert property (
    $fell(sys_rst) |-> vec_fields == '0 && vec_num == 7'h00 && !vec_valid)
    else $error("outputs not cleared by reset");

  ack_idle_a: assert property (
    !ack_in.valid |=> !vec_valid ##0 $stable(vec_num))
    else $error("vector pulse without accept");

  wr_rd_c: cover property (
    reg_wr && reg_addr == pvn_pkg::OFF_T1_WRAP ##1 reg_rd && reg_addr == pvn_pkg::OFF_T1_WRAP);

  standby_ack_c: cover property (
    standby && ack_in.valid ##1 vec_valid && vec_num != 7'h00);

  wr_ack_same_c: cover property (
    reg_wr && ack_in.valid);

  max_vec_c: cover property (
    vec_valid && vec_num == 7'h7f);

  refused_src_c: cover property (
    ack_in.valid && ack_in.src > pvn_pkg::SRC_S1_RXF);

endmodule : pvn_regs

// ==== tb/pvn_src_model.sv ====
// partner model: interrupt source acceptance seen by the vector bank
`timescale 1ns/10ps

module pvn_src_model (
  input wire logic clk_sys, // system clock
  input wire logic go, // accept one source next cycle
  input wire logic [3:0] src_sel, // source code to accept
  output pvn_pkg::pvn_ack_s ack_in // acceptance to the bank
);
  pvn_pkg::pvn_ack_s ack_reg = '0;

  assign ack_in = ack_reg;

  // idle source code keeps changing so a stale code never looks valid
  always @(posedge clk_sys)
  begin
    ack_reg.valid <= go;
    ack_reg.src <= go ? pvn_pkg::pvn_src_e'(src_sel) : pvn_pkg::pvn_src_e'(~ack_reg.src);
  end
endmodule : pvn_src_model

// ==== tb/testbench.sv ====
// testbench: register access, reserved bits, standby and vector lookup
`timescale 1ns/10ps

module testbench;
  logic clk_sys = 0;
  logic sys_rst = 1;
  logic [3:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [15:0] reg_rdata;
  logic standby = 0;
  logic go = 0;
  logic [3:0] src_sel = '0;
  pvn_pkg::pvn_ack_s ack_in;
  pvn_pkg::pvn_vec_s vec_fields;
  logic [6:0] vec_num;
  logic vec_valid;
  int err_total = 0;
  int check_count = 0;
  logic [15:0] v;
  localparam int SREG [13] = '{0, 0, 1, 2, 2, 3, 3, 4, 4, 5, 5, 6, 6};
  localparam logic [12:0] IS_HI = 13'h0aad;

  always #20 clk_sys = ~clk_sys;

  pvn_regs pvn_regs_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby(standby), .ack_in(ack_in),
    .vec_fields(vec_fields), .vec_num(vec_num), .vec_valid(vec_valid));

  pvn_src_model pvn_src_model_inst (.clk_sys(clk_sys), .go(go), .src_sel(src_sel), .ack_in(ack_in));

  // hi field walks up from 0, lo field walks down from 127
  function automatic logic [15:0] wv(input int i);
    return {1'b0, 7'(i * 21), 1'b0, 7'(127 - i * 19)};
  endfunction : wv

  function automatic logic [15:0] msk(input int i);
    return (i == 1) ? pvn_pkg::MASK_HIGH : pvn_pkg::MASK_PAIR;
  endfunction : msk

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  // write then read with no gap between the strobes
  task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : wr_rd

  // accept one source and compare the vector handed back
  task automatic acc(input logic [3:0] s, input logic [6:0] exp);
    int n;
    n = 0;
    @(posedge clk_sys);
    go <= 1'b1;
    src_sel <= s;
    @(posedge clk_sys);
    go <= 1'b0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (vec_valid !== 1'b1 && n < 8);
    if (vec_valid !== 1'b1)
    begin
      err_total++;
      $display("MISMATCH t=%0t no vector strobe", $time);
      wrap_up();
    end
    else
      chk({9'h000, vec_num}, {9'h000, exp});
  endtask : acc

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      rd(4'(2 * i), pvn_pkg::RST_VAL);
    for (int i = 0; i < 7; i++)
    begin
      wr(4'(2 * i), 16'hffff);
      rd(4'(2 * i), msk(i));
    end
    // writes during standby must still land and survive the exit
    standby <= 1'b1;
    for (int i = 0; i < 7; i++)
      wr(4'(2 * i), wv(i));
    wr(4'h1, 16'h5555);
    wr(4'he, 16'h5555);
    v = wv(0);
    acc(4'h1, v[6:0]);
    standby <= 1'b0;
    rd(4'h1, 16'h0000);
    rd(4'hf, 16'h0000);
    for (int i = 0; i < 7; i++)
      rd(4'(2 * i), wv(i) & msk(i));
    for (int s = 0; s < 13; s++)
    begin
      v = wv(SREG[s]);
      acc(4'(s), IS_HI[s] ? v[14:8] : v[6:0]);
    end
    acc(4'hd, 7'h00);
    // an accept in the cycle of a write still hands out the old field
    fork
      acc(4'h1, 7'h7f);
      begin
        @(posedge clk_sys);
        wr(4'h0, 16'h0000);
      end
    join
    acc(4'h1, 7'h00);
    wr_rd(4'h6, 16'h3a5c, 16'h3a5c);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(4'hc, pvn_pkg::RST_VAL);
    acc(4'h0, 7'h00);
    wrap_up();
  end
endmodule : testbench
